// ===== logic/lfp_fifo.sv
// word fifo with valid and ready on both sides and a fill level
// assumes DEPTH is a power of two
module lfp_fifo #(
   parameter int W     = 64,
   parameter int DEPTH = 8
) (
   input  wire logic                       clk,
   input  wire logic                       rst_b,
   input  wire logic                       in_valid,
   output wire logic                       in_ready,
   input  wire logic [W-1:0]               in_data,
   output wire logic                       out_valid,
   input  wire logic                       out_ready,
   output wire logic [W-1:0]               out_data,
   output wire logic [$clog2(DEPTH):0]     level
);
   localparam int AW = $clog2(DEPTH);

   logic [W-1:0] mem [DEPTH];
   logic [AW:0]  wr_q;
   logic [AW:0]  rd_q;
   logic         push;
   logic         pop;

   assign level     = wr_q - rd_q;
   assign in_ready  = (level != DEPTH[AW:0]);
   assign out_valid = (level != '0);
   assign push      = in_valid && in_ready;
   assign pop       = out_valid && out_ready;
   assign out_data  = mem[rd_q[AW-1:0]];

   always_ff @(posedge clk) begin
      if (push) begin
         mem[wr_q[AW-1:0]] <= in_data;
      end
   end

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         wr_q <= '0;
         rd_q <= '0;
      end else begin
         if (push) begin
            wr_q <= wr_q + 1'b1;
         end
         if (pop) begin
            rd_q <= rd_q + 1'b1;
         end
      end
   end
endmodule

// ===== logic/lfp_if.sv
// carrier between the transmit framing port and its user and receiver
// assumes both ends run on one common clock supplied outside
interface lfp_if
   import lfp_pkg::*;
#(
   parameter int LANES = LFP_LANES
);
   logic                          data_clk_en;
   logic                          data_rst_b;
   logic [LANES*LFP_LANE_W-1:0]   tdata;
   logic                          tvalid;
   logic                          tready;
   logic [LFP_BYTES-1:0]          frame_first_byte_pos;
   logic [LFP_BYTES-1:0]          multiframe_first_byte_pos;
   logic                          sysref;
   logic                          sync_b;
   logic [LANES*LFP_LANE_W-1:0]   serdes_lane_word;
   logic [LANES*LFP_BYTES-1:0]    serdes_control_char_flags;

   modport dev (
      output data_clk_en, data_rst_b, tready, frame_first_byte_pos,
             multiframe_first_byte_pos, serdes_lane_word, serdes_control_char_flags,
      input  tdata, tvalid, sysref, sync_b
   );
   modport host (
      input  data_clk_en, data_rst_b, tready, frame_first_byte_pos,
             multiframe_first_byte_pos, serdes_lane_word, serdes_control_char_flags,
      output tdata, tvalid, sysref, sync_b
   );
endinterface

// ===== logic/lfp_pkg.sv
// shared constants and types of the lane transmit framing port
// assumes both ends and the fifo are compiled after this package
package lfp_pkg;
   // ----------------------------------------------------------------
   // data layout
   // ----------------------------------------------------------------
   localparam int LFP_BYTES   = 4;
   localparam int LFP_BYTE_W  = 8;
   localparam int LFP_LANE_W  = 32;
   localparam int LFP_CNT_W   = 8;

   // ----------------------------------------------------------------
   // control characters and per-byte flag patterns
   // ----------------------------------------------------------------
   localparam logic [7:0] LFP_K_COMMA    = 8'hbc;
   localparam logic [7:0] LFP_K_MF_START = 8'h1c;
   localparam logic [7:0] LFP_K_MF_END   = 8'h7c;
   localparam logic [7:0] LFP_BYTE_ZERO  = 8'h00;
   localparam logic [3:0] LFP_FLAGS_ALL  = 4'hf;
   localparam logic [3:0] LFP_FLAGS_NONE = 4'h0;
   localparam logic [3:0] LFP_POS_NONE   = 4'h0;
   localparam logic [3:0] LFP_POS_BYTE0  = 4'h1;

   // ----------------------------------------------------------------
   // configuration defaults
   // ----------------------------------------------------------------
   localparam int LFP_LANES         = 2;
   localparam int LFP_F             = 2;
   localparam int LFP_K             = 16;
   localparam int LFP_DIV           = 1;
   localparam int LFP_SUBCLASS      = 1;
   localparam int LFP_ILA_MF        = 4;
   localparam int LFP_FIFO_DEPTH    = 8;
   localparam int LFP_FIFO_MARGIN   = 3;
   localparam int LFP_SYNC_COMMAS   = 4;
   localparam int LFP_SYSREF_PERIOD = 64;

   typedef enum logic [1:0] {
      LFP_ST_SYNC,
      LFP_ST_ILA,
      LFP_ST_DATA
   } lfp_link_state_e;
endpackage

// ===== logic/lfp_tx_dev.sv
// transmit end of the lane framing port: stream sink, frame indicators,
// link start-up and the per-lane word towards the serialiser
// assumes sysref and sync_b are synchronous to clk
//
// What this block does
// R1: output data clock enable, rate from line
// R2: output active-low data reset, shared by lanes
// R3: source puts lane k at bits 32k up
// R4: serialise each lane word low byte first
// R5: sink drives ready when data is accepted
// R6: frame-start position shown one cycle ahead; here it stands in the cycle the word is taken
// R7: one-hot per byte frame-start encoding
// R8: several frame-start bits when frames are short
// R9: multiframe-start position, same encoding and advance
// R10: one indicator set applies to all lanes
// R11: sysref used only in subclass 1 mode
// R12: one external source makes sysref for both
// R13: receiver holds sync low until commas aligned
// R14: 32 bits and 4 control flags per lane
// R15: commas while sync low, then alignment, data
module lfp_tx_dev
   import lfp_pkg::*;
#(
   parameter int LANES      = LFP_LANES,
   parameter int F          = LFP_F,
   parameter int K          = LFP_K,
   parameter int DIV        = LFP_DIV,
   parameter int SUBCLASS   = LFP_SUBCLASS,
   parameter int ILA_MF     = LFP_ILA_MF,
   parameter int FIFO_DEPTH = LFP_FIFO_DEPTH
) (
   input  wire logic  clk,
   input  wire logic  rst_b,
   lfp_if.dev         lnk,
   output logic       link_up_q
);
   // ----------------------------------------------------------------
   // derived sizes
   // ----------------------------------------------------------------
   localparam int W         = LANES*LFP_LANE_W;
   localparam int MF_WORDS  = (F*K)/LFP_BYTES;
   localparam int ILA_WORDS = ILA_MF*MF_WORDS;
   localparam int LW        = $clog2(FIFO_DEPTH)+1;

   typedef logic [LFP_CNT_W-1:0] lfp_cnt_t;

   localparam lfp_cnt_t DIV_LAST  = lfp_cnt_t'(DIV-1);
   localparam lfp_cnt_t MFW_LAST  = lfp_cnt_t'(MF_WORDS-1);
   localparam lfp_cnt_t ILA_LAST  = lfp_cnt_t'(ILA_WORDS-1);
   localparam logic [LW-1:0] READY_LEVEL = LW'(FIFO_DEPTH-LFP_FIFO_MARGIN);

   // frame-start flag of byte i, set where its frame-octet index is 0, with byte 0 at index fo
   function automatic logic [LFP_BYTES-1:0] frame_starts(input lfp_cnt_t fo);
      logic [LFP_BYTES-1:0] b;
      lfp_cnt_t             p;
      b = '0;
      p = fo;
      for (int i = 0; i < LFP_BYTES; i++) begin
         b[i] = (p == '0);
         p    = (p == lfp_cnt_t'(F-1)) ? '0 : p + 1'b1;
      end
      return b;
   endfunction

   function automatic lfp_cnt_t frame_step(input lfp_cnt_t fo);
      lfp_cnt_t p;
      p = fo;
      for (int i = 0; i < LFP_BYTES; i++) begin
         p = (p == lfp_cnt_t'(F-1)) ? '0 : p + 1'b1;
      end
      return p;
   endfunction

   lfp_link_state_e      state_q;
   lfp_cnt_t             div_q;
   logic                 tick_q;
   logic                 data_rst_b_q;
   logic                 sysref_q;
   logic                 sr_pend_q;
   lfp_cnt_t             lmfc_q;
   lfp_cnt_t             ila_q;
   lfp_cnt_t             ila_w_q;
   lfp_cnt_t             wpos_q;
   lfp_cnt_t             fo_q;
   logic                 tready_q;
   logic [3:0]           sof_q;
   logic [3:0]           somf_q;
   logic [W-1:0]         word_q;
   logic [LANES*4-1:0]   flags_q;
   logic                 accept;
   logic                 drain;
   logic                 f_valid;
   logic [W-1:0]         f_data;
   logic [LW-1:0]        f_level;
   lfp_cnt_t             wpos_d;
   lfp_cnt_t             fo_d;

   // ----------------------------------------------------------------
   // data clock enable and data reset
   // ----------------------------------------------------------------
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         div_q  <= '0;
         tick_q <= 1'b0;
      end else if (div_q == DIV_LAST) begin
         div_q  <= '0;
         tick_q <= 1'b1; // R1
      end else begin
         div_q  <= div_q + 1'b1;
         tick_q <= 1'b0;
      end
   end

   // release only once the enable runs, so the user never sees a
   // reset edge without a data tick behind it
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         data_rst_b_q <= 1'b0;
      end else if (tick_q) begin
         data_rst_b_q <= 1'b1; // R2
      end
   end

   assign lnk.data_clk_en = tick_q;
   assign lnk.data_rst_b  = data_rst_b_q;

   // ----------------------------------------------------------------
   // sysref and multiframe clock
   // ----------------------------------------------------------------
   // sysref may pulse between ticks, so its edge is held until the next one
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         sysref_q  <= 1'b0;
         sr_pend_q <= 1'b0;
      end else begin
         sysref_q <= lnk.sysref;
         if (SUBCLASS == 1 && lnk.sysref && !sysref_q) begin
            sr_pend_q <= 1'b1; // R11 R12
         end else if (tick_q) begin
            sr_pend_q <= 1'b0;
         end
      end
   end

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         lmfc_q <= '0;
      end else if (tick_q) begin
         if (sr_pend_q || lmfc_q == MFW_LAST) begin
            lmfc_q <= '0; // R11
         end else begin
            lmfc_q <= lmfc_q + 1'b1;
         end
      end
   end

   // ----------------------------------------------------------------
   // link start-up
   // ----------------------------------------------------------------
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         state_q <= LFP_ST_SYNC;
         ila_q   <= '0;
         ila_w_q <= '0;
      end else if (tick_q) begin
         case (state_q)
            LFP_ST_SYNC: begin
               ila_q   <= '0;
               ila_w_q <= '0;
               // R13 R15: leave only on a high request, on the lmfc edge in subclass 1
               if (lnk.sync_b && (SUBCLASS != 1 || lmfc_q == MFW_LAST)) begin
                  state_q <= LFP_ST_ILA;
               end
            end
            LFP_ST_ILA: begin
               ila_q   <= ila_q + 1'b1;
               ila_w_q <= (ila_w_q == MFW_LAST) ? '0 : ila_w_q + 1'b1;
               if (!lnk.sync_b) begin
                  state_q <= LFP_ST_SYNC; // R15
               end else if (ila_q == ILA_LAST) begin
                  state_q <= LFP_ST_DATA; // R15
               end
            end
            LFP_ST_DATA: begin
               if (!lnk.sync_b) begin
                  state_q <= LFP_ST_SYNC; // R15
               end
            end
            default: begin
               state_q <= LFP_ST_SYNC;
            end
         endcase
      end
   end

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         link_up_q <= 1'b0;
      end else begin
         link_up_q <= (state_q == LFP_ST_DATA);
      end
   end

   // ----------------------------------------------------------------
   // stream sink and frame position indicators
   // ----------------------------------------------------------------
   assign accept = tick_q && tready_q && lnk.tvalid; // R5

   // the margin covers the word that may land while ready is still high
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         tready_q <= 1'b0;
      end else begin
         tready_q <= (state_q == LFP_ST_DATA) && (f_level <= READY_LEVEL); // R5
      end
   end

   always_comb begin
      wpos_d = wpos_q;
      fo_d   = fo_q;
      if (state_q != LFP_ST_DATA) begin
         wpos_d = '0;
         fo_d   = '0;
      end else if (accept) begin
         wpos_d = (wpos_q == MFW_LAST) ? '0 : wpos_q + 1'b1;
         fo_d   = frame_step(fo_q);
      end
   end

   // indicators always describe the next word to be accepted, so they
   // stand from the cycle after the previous word is taken until that word is taken
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         wpos_q <= '0;
         fo_q   <= '0;
         sof_q  <= LFP_POS_NONE;
         somf_q <= LFP_POS_NONE;
      end else begin
         wpos_q <= wpos_d;
         fo_q   <= fo_d;
         sof_q  <= frame_starts(fo_d); // R6 R7 R8
         somf_q <= (wpos_d == '0) ? LFP_POS_BYTE0 : LFP_POS_NONE; // R9
      end
   end

   // one set for every lane slice of tdata
   assign lnk.tready                    = tready_q;
   assign lnk.frame_first_byte_pos      = sof_q; // R10
   assign lnk.multiframe_first_byte_pos = somf_q; // R10

   lfp_fifo #(
      .W     (W),
      .DEPTH (FIFO_DEPTH)
   ) u_fifo (
      .clk       (clk),
      .rst_b     (rst_b),
      .in_valid  (accept),
      .in_ready  (),
      .in_data   (lnk.tdata),
      .out_valid (f_valid),
      .out_ready (drain),
      .out_data  (f_data),
      .level     (f_level)
   );

   // ----------------------------------------------------------------
   // word towards the serialiser
   // ----------------------------------------------------------------
   assign drain = tick_q && (state_q == LFP_ST_DATA);

   // an empty fifo in data state sends zero bytes: the source must keep up
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         word_q  <= '0;
         flags_q <= '0;
      end else if (tick_q) begin
         for (int l = 0; l < LANES; l++) begin
            for (int i = 0; i < LFP_BYTES; i++) begin
               // R4 R14: byte 0 in the low bits goes out first
               case (state_q)
                  LFP_ST_SYNC: begin
                     word_q[l*LFP_LANE_W+i*LFP_BYTE_W +: LFP_BYTE_W] <= LFP_K_COMMA; // R15
                     flags_q[l*LFP_BYTES+i] <= 1'b1;
                  end
                  LFP_ST_ILA: begin
                     if (ila_w_q == '0 && i == 0) begin
                        word_q[l*LFP_LANE_W+i*LFP_BYTE_W +: LFP_BYTE_W] <= LFP_K_MF_START;
                        flags_q[l*LFP_BYTES+i] <= 1'b1;
                     end else if (ila_w_q == MFW_LAST && i == LFP_BYTES-1) begin
                        word_q[l*LFP_LANE_W+i*LFP_BYTE_W +: LFP_BYTE_W] <= LFP_K_MF_END;
                        flags_q[l*LFP_BYTES+i] <= 1'b1;
                     end else begin
                        word_q[l*LFP_LANE_W+i*LFP_BYTE_W +: LFP_BYTE_W] <=
                           LFP_BYTE_W'({ila_q, 2'(i)});
                        flags_q[l*LFP_BYTES+i] <= 1'b0;
                     end
                  end
                  default: begin
                     word_q[l*LFP_LANE_W+i*LFP_BYTE_W +: LFP_BYTE_W] <= f_valid ?
                        f_data[l*LFP_LANE_W+i*LFP_BYTE_W +: LFP_BYTE_W] : LFP_BYTE_ZERO;
                     flags_q[l*LFP_BYTES+i] <= 1'b0;
                  end
               endcase
            end
         end
      end
   end

   assign lnk.serdes_lane_word          = word_q;
   assign lnk.serdes_control_char_flags = flags_q;
endmodule

// ===== logic/lfp_tx_host.sv
// far end of the lane framing port: user data source, sysref source
// and a minimal receiver that raises the sync request after commas
// assumes the same clk as the transmit end
module lfp_tx_host
   import lfp_pkg::*;
#(
   parameter int LANES         = LFP_LANES,
   parameter int SYNC_COMMAS   = LFP_SYNC_COMMAS,
   parameter int SYSREF_PERIOD = LFP_SYSREF_PERIOD
) (
   input  wire logic                  clk,
   input  wire logic                  rst_b,
   lfp_if.host                        lnk,
   input  wire logic                  src_en,
   output logic                       aligned_q,
   output logic [LFP_LANE_W-1:0]      words_sent_q
);
   localparam int W = LANES*LFP_LANE_W;
   typedef logic [LFP_CNT_W-1:0] lfp_cnt_t;
   localparam lfp_cnt_t COMMA_LAST = lfp_cnt_t'(SYNC_COMMAS-1);
   localparam lfp_cnt_t SR_LAST    = lfp_cnt_t'(SYSREF_PERIOD-1);

   lfp_cnt_t     comma_q;
   lfp_cnt_t     sr_cnt_q;
   logic         sysref_q;
   logic         tvalid_q;
   logic [W-1:0] tdata_q;
   logic         all_comma;
   logic         accept;

   // ----------------------------------------------------------------
   // sync request
   // ----------------------------------------------------------------
   always_comb begin
      all_comma = (lnk.serdes_control_char_flags == '1);
      for (int l = 0; l < LANES*LFP_BYTES; l++) begin
         if (lnk.serdes_lane_word[l*LFP_BYTE_W +: LFP_BYTE_W] != LFP_K_COMMA) begin
            all_comma = 1'b0;
         end
      end
   end

   // once aligned the request stays high; only reset reopens alignment
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         comma_q   <= '0;
         aligned_q <= 1'b0;
      end else if (!lnk.data_rst_b) begin
         comma_q   <= '0;
         aligned_q <= 1'b0;
      end else if (lnk.data_clk_en && !aligned_q) begin
         if (!all_comma) begin
            comma_q <= '0;
         end else if (comma_q == COMMA_LAST) begin
            aligned_q <= 1'b1; // R13
         end else begin
            comma_q <= comma_q + 1'b1;
         end
      end
   end

   assign lnk.sync_b = aligned_q; // R13

   // ----------------------------------------------------------------
   // sysref pulse, one clock wide
   // ----------------------------------------------------------------
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         sr_cnt_q <= '0;
         sysref_q <= 1'b0;
      end else begin
         sysref_q <= (sr_cnt_q == SR_LAST); // R11 R12
         sr_cnt_q <= (sr_cnt_q == SR_LAST) ? '0 : sr_cnt_q + 1'b1;
      end
   end

   assign lnk.sysref = sysref_q;

   // ----------------------------------------------------------------
   // data source: lane k carries count*LANES+k in its slice
   // ----------------------------------------------------------------
   assign accept = lnk.data_clk_en && lnk.tready && tvalid_q;

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         tvalid_q     <= 1'b0;
         words_sent_q <= '0;
      end else if (!lnk.data_rst_b) begin
         tvalid_q     <= 1'b0;
         words_sent_q <= '0;
      end else begin
         tvalid_q <= src_en;
         if (accept) begin
            words_sent_q <= words_sent_q + 1'b1;
         end
      end
   end

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         tdata_q <= '0;
      end else begin
         for (int l = 0; l < LANES; l++) begin
            tdata_q[l*LFP_LANE_W +: LFP_LANE_W] <= // R3
               LFP_LANE_W'((accept ? words_sent_q + 1'b1 : words_sent_q) * LANES + l);
         end
      end
   end

   assign lnk.tvalid = tvalid_q;
   assign lnk.tdata  = tdata_q;
endmodule

// ===== sim/lfp_link_chk.sv
// assertions on the link joining the transmit end to its far end
// assumes one clock; interface signals are passed in by name
module lfp_link_chk
   import lfp_pkg::*;
#(
   parameter int LANES = LFP_LANES,
   parameter int F     = LFP_F,
   parameter int K     = LFP_K
) (
   input wire logic                        clk,
   input wire logic                        rst_b,
   input wire logic                        data_clk_en,
   input wire logic                        data_rst_b,
   input wire logic [LANES*LFP_LANE_W-1:0] tdata,
   input wire logic                        tvalid,
   input wire logic                        tready,
   input wire logic [LFP_BYTES-1:0]        frame_first_byte_pos,
   input wire logic [LFP_BYTES-1:0]        multiframe_first_byte_pos,
   input wire logic                        sysref,
   input wire logic                        sync_b,
   input wire logic [LANES*LFP_LANE_W-1:0] serdes_lane_word,
   input wire logic [LANES*LFP_BYTES-1:0]  serdes_control_char_flags
);
   // ------------
   // word position inside the multiframe
   // ------------
   localparam int MF_WORDS = F * K / LFP_BYTES;
   logic [LFP_CNT_W-1:0] mf_pos_q;
   logic [LFP_BYTES-1:0] sof_exp;
   always_comb begin
      for (int i = 0; i < LFP_BYTES; i++) begin
         sof_exp[i] = (i % F) == 0;
      end
   end
   // cleared during a sync request since the device restarts at position 0
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         mf_pos_q <= '0;
      end else if (!sync_b) begin
         mf_pos_q <= '0;
      end else if (data_clk_en && tready && tvalid) begin
         mf_pos_q <= (int'(mf_pos_q) == MF_WORDS - 1) ? '0 : mf_pos_q + 1'b1;
      end
   end
   // ------------
   // properties
   // ------------
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!rst_b);
   sequence s_sync_held;
      (!sync_b && data_clk_en) [*2];
   endsequence
   sequence s_ila_head;
      serdes_lane_word[7:0] == LFP_K_MF_START && serdes_control_char_flags[0];
   endsequence
   a_comma_fill:
      assert property (s_sync_held |=> &serdes_control_char_flags
         && serdes_lane_word == {LANES * LFP_BYTES{LFP_K_COMMA}})
      else $error("no comma fill during sync request");
   a_ila_soon:
      assert property ($rose(sync_b) |-> ##[1:24] s_ila_head)
      else $error("alignment sequence did not start");
   a_ready_quiet:
      assert property ((!sync_b) [*3] |-> !tready)
      else $error("ready during sync request");
   a_frame_pos:
      assert property (tready |-> frame_first_byte_pos == sof_exp)
      else $error("frame start position wrong");
   a_mf_pos:
      assert property (tready |-> multiframe_first_byte_pos
         == ((mf_pos_q == '0) ? LFP_POS_BYTE0 : LFP_POS_NONE))
      else $error("multiframe start position wrong");
   a_data_flags:
      assert property (tready |-> serdes_control_char_flags == '0)
      else $error("control flag set on user data");
   a_sync_after_comma:
      assert property ($rose(sync_b) |-> $past(&serdes_control_char_flags))
      else $error("sync released without commas");
   a_sysref_pulse:
      assert property ($rose(sysref) |=> !sysref)
      else $error("sysref pulse too long");
   a_rst_after_tick:
      assert property ($rose(data_rst_b) |-> $past(data_clk_en))
      else $error("data reset left before a tick");
   a_reset_ready:
      assert property (!data_rst_b |-> !tready && data_rst_b == 1'b0 ##1 data_clk_en)
      else $error("ready or tick wrong in data reset");
endmodule

// ===== sim/tb_lane_tx_data_framing_port.sv
// self-checking bench: both ends joined, and a second transmit end driven
// here; assumes design and checker compiled first
module tb_lane_tx_data_framing_port;
   timeunit 1ns;
   timeprecision 100ps;
   import lfp_pkg::*;
   localparam int W   = LFP_LANES * LFP_LANE_W;
   localparam int DLY = 2;
   logic          clk = 1'b0;
   logic          rst_b = 1'b0;
   logic          src_en = 1'b0;
   logic          up1, up2, aligned, got;
   logic [31:0]   sent;
   logic [W-1:0]  t2_data = '0;
   logic          t2_valid = 1'b0, t2_sysref = 1'b0, t2_sync_b = 1'b0;
   int            err_total = 0, cmp_count = 0, cyc = 0, acc1 = 0, acc2 = 0;
   logic [W-1:0]  q1[$], q2[$];
   lfp_if lnk_if ();
   lfp_if lnk2_if ();
   assign lnk2_if.tdata  = t2_data;
   assign lnk2_if.tvalid = t2_valid;
   assign lnk2_if.sysref = t2_sysref;
   assign lnk2_if.sync_b = t2_sync_b;
   lfp_tx_dev lfp_tx_dev_inst (.clk(clk), .rst_b(rst_b), .lnk(lnk_if.dev), .link_up_q(up1));
   lfp_tx_host lfp_tx_host_inst (.clk(clk), .rst_b(rst_b), .lnk(lnk_if.host), .src_en(src_en),
      .aligned_q(aligned), .words_sent_q(sent));
   // single-octet frames here make every byte a frame start
   lfp_tx_dev #(.F(1)) lfp_tx_dev_inst2 (.clk(clk), .rst_b(rst_b), .lnk(lnk2_if.dev),
      .link_up_q(up2));
   lfp_link_chk #(.LANES(LFP_LANES), .F(LFP_F), .K(LFP_K)) lfp_link_chk_inst (.clk(clk),
      .rst_b(rst_b), .data_clk_en(lnk_if.data_clk_en), .data_rst_b(lnk_if.data_rst_b),
      .tdata(lnk_if.tdata), .tvalid(lnk_if.tvalid), .tready(lnk_if.tready),
      .frame_first_byte_pos(lnk_if.frame_first_byte_pos),
      .multiframe_first_byte_pos(lnk_if.multiframe_first_byte_pos), .sysref(lnk_if.sysref),
      .sync_b(lnk_if.sync_b), .serdes_lane_word(lnk_if.serdes_lane_word),
      .serdes_control_char_flags(lnk_if.serdes_control_char_flags));
   initial begin
      forever #12.5 clk = ~clk;
   end
   // ------------
   // checking and closing
   // ------------
   task automatic chk(input string what, input logic [W-1:0] exp, input logic [W-1:0] seen);
      cmp_count++;
      if (seen !== exp) begin
         err_total++;
         $display("unexpected %s: expected %h, seen %h", what, exp, seen);
      end
   endtask
   task automatic stop_test();
      $display("comparisons %0d, mismatches %0d", cmp_count, err_total);
      if (err_total == 0 && cmp_count > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask
   always @(posedge clk) begin
      cyc <= cyc + 1;
      t2_sysref <= #DLY (cyc % LFP_SYSREF_PERIOD == 0);
      if (cyc == 5000) begin
         err_total++;
         stop_test();
      end
   end
   // ------------
   // models: reads here see values from before the edge
   // ------------
   always @(posedge clk) begin
      if (q2.size() > 0 && lnk2_if.serdes_control_char_flags === '0
          && lnk2_if.serdes_lane_word !== '0) begin
         chk("lane word", q2.pop_front(), lnk2_if.serdes_lane_word);
      end
      if (rst_b && lnk2_if.data_clk_en && lnk2_if.tready && t2_valid) begin
         chk("frame start", LFP_FLAGS_ALL, lnk2_if.frame_first_byte_pos);
         chk("mf start", (acc2 % 4 == 0) ? 1 : 0, lnk2_if.multiframe_first_byte_pos);
         q2.push_back(t2_data);
         acc2++;
      end
      if (q1.size() > 0 && lnk_if.serdes_control_char_flags === '0
          && lnk_if.serdes_lane_word !== '0) begin
         chk("lane word 1", q1.pop_front(), lnk_if.serdes_lane_word);
      end
      if (rst_b && lnk_if.data_clk_en && lnk_if.tready && lnk_if.tvalid) begin
         chk("frame start 1", 4'h5, lnk_if.frame_first_byte_pos);
         chk("mf start 1", (acc1 % 8 == 0) ? 1 : 0, lnk_if.multiframe_first_byte_pos);
         q1.push_back(lnk_if.tdata);
         acc1++;
      end
   end
   // ------------
   // bench-driven end: stream with random stalls, tvalid held until taken
   // ------------
   task automatic stream2(input int n);
      int  done_n;
      done_n = 0;
      while (done_n < n) begin
         @(posedge clk);
         got = t2_valid && lnk2_if.tready && lnk2_if.data_clk_en;
         done_n += int'(got);
         #DLY;
         if (got || !t2_valid) begin
            t2_valid = (done_n < n) && 1'($urandom);
            t2_data  = {$urandom, $urandom};
         end
      end
   endtask
   task automatic relink2();
      t2_sync_b = 1'b0;
      repeat (8) @(posedge clk);
      #DLY;
      chk("comma word", {LFP_LANES * LFP_BYTES{LFP_K_COMMA}}, lnk2_if.serdes_lane_word);
      chk("comma flags", {LFP_LANES * LFP_BYTES{1'b1}}, lnk2_if.serdes_control_char_flags);
      chk("ready in sync", 1'b0, lnk2_if.tready);
      chk("link down", 1'b0, up2);
      acc2 = 0;
      t2_sync_b = 1'b1;
      for (int i = 0; i < 300 && !up2; i++) @(posedge clk);
      #DLY;
      chk("link up", 1'b1, up2);
      chk("ready in data", 1'b1, lnk2_if.tready);
      stream2(24);
      for (int i = 0; i < 100 && q2.size() > 0; i++) @(posedge clk);
      #DLY;
      chk("words left", 0, q2.size());
   endtask
   initial begin
      void'($urandom(32'h0697));
      repeat (5) @(posedge clk);
      #DLY rst_b = 1'b1;
      for (int i = 0; i < 400 && !up1; i++) @(posedge clk);
      #DLY;
      chk("link up 1", 1'b1, up1);
      chk("aligned", 1'b1, aligned);
      chk("data reset", 1'b1, lnk_if.data_rst_b);
      for (int i = 0; i < 308; i++) begin
         @(posedge clk);
         #DLY src_en = (i < 300) && 1'($urandom);
      end
      chk("words sent", acc1, sent);
      chk("words left 1", 0, q1.size());
      $display("test joined link done");
      relink2();
      $display("test first link of driven end done");
      relink2();
      $display("test resync of driven end done");
      stop_test();
   end
endmodule
